//--- rtl/dme_pkg.sv
package dme_pkg;
	// Field layout of the debug status and control register.
	localparam int MODE_LSB = 14;
	localparam int MODE_MSB = 15;
	localparam int HALT_BIT = 15;
	localparam int MON_BIT = 14;
	localparam int DSCR_W = 32;
	localparam logic [31:0] DSCR_RESET = 32'h0000_0000;
	// Breakpoint and watchpoint units.
	localparam int NUM_BP = 4;
	localparam int NUM_WP = 4;
	localparam int ADDR_W = 32;

	typedef enum logic [3:0] {
		DME_IDLE = 4'h1,
		DME_PEND = 4'h2,
		DME_HALT = 4'h4,
		DME_MON = 4'h8
	} dme_state_e;
endpackage : dme_pkg

//--- rtl/dme_match_if.sv
`timescale 1ns/1ps
interface dme_match_if;
	logic bp_hit;
	logic wp_hit;
	modport unit (output bp_hit, output wp_hit);
	modport ctrl (input bp_hit, input wp_hit);
endinterface : dme_match_if

//--- rtl/dme_matcher.sv
`timescale 1ns/1ps
module dme_matcher
	import dme_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Comparator setup
	input wire logic [NUM_BP*ADDR_W-1:0] bp_addr_i,
	input wire logic [NUM_BP-1:0] bp_active_i,
	input wire logic [NUM_WP*ADDR_W-1:0] wp_addr_i,
	input wire logic [NUM_WP-1:0] wp_active_i,
	// Observed traffic
	input wire logic fetch_valid_i,
	input wire logic [ADDR_W-1:0] fetch_addr_i,
	input wire logic data_valid_i,
	input wire logic [ADDR_W-1:0] data_addr_i,
	input wire logic events_on_i,
	// Match results
	dme_match_if.unit m
);
	logic [NUM_BP-1:0] bp_eq;
	logic [NUM_WP-1:0] wp_eq;
	logic bp_hit_ff;
	logic wp_hit_ff;

	genvar g;
	generate
		for (g = 0; g < NUM_BP; g++) begin : g_bp
			assign bp_eq[g] = bp_active_i[g] && fetch_valid_i &&
				(bp_addr_i[g*ADDR_W +: ADDR_W] == fetch_addr_i);
		end
		for (g = 0; g < NUM_WP; g++) begin : g_wp
			assign wp_eq[g] = wp_active_i[g] && data_valid_i &&
				(wp_addr_i[g*ADDR_W +: ADDR_W] == data_addr_i);
		end
	endgenerate

	// Matches are registered; events_on gates them at the source.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bp_hit_ff <= 1'b0;
			wp_hit_ff <= 1'b0;
		end else begin
			bp_hit_ff <= events_on_i && (|bp_eq);
			wp_hit_ff <= events_on_i && (|wp_eq);
		end
	end

	assign m.bp_hit = bp_hit_ff;
	assign m.wp_hit = wp_hit_ff;
endmodule : dme_matcher

//--- rtl/dme_debug_ctrl.sv
`timescale 1ns/1ps
module dme_debug_ctrl
	import dme_pkg::*;
(
	// Clock and resets
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic debug_reset_n_i,
	// Enable pin (asynchronous to the core)
	input wire logic invasive_debug_enable_i,
	// Register write port from the core
	input wire logic dscr_wr_i,
	input wire logic [dme_pkg::DSCR_W-1:0] dscr_wdata_i,
	output logic [dme_pkg::DSCR_W-1:0] debug_status_control_reg_o,
	// Comparator setup
	input wire logic [dme_pkg::NUM_BP*dme_pkg::ADDR_W-1:0] bp_addr_i,
	input wire logic [dme_pkg::NUM_BP-1:0] bp_active_i,
	input wire logic [dme_pkg::NUM_WP*dme_pkg::ADDR_W-1:0] wp_addr_i,
	input wire logic [dme_pkg::NUM_WP-1:0] wp_active_i,
	// Pipeline observation
	input wire logic fetch_valid_i,
	input wire logic [dme_pkg::ADDR_W-1:0] fetch_addr_i,
	input wire logic data_valid_i,
	input wire logic [dme_pkg::ADDR_W-1:0] data_addr_i,
	input wire logic instr_done_i,
	// Interrupts and restart
	input wire logic irq_pending_i,
	input wire logic irq_masked_i,
	input wire logic restart_i,
	// Results to the core
	output logic core_stall_o,
	output logic halt_o,
	output logic monitor_exc_o,
	output logic wp_data_commit_o,
	output logic irq_take_o
);
	import dme_pkg::*;

	logic [DSCR_W-1:0] dscr_ff;
	logic [2:0] en_sync_ff;
	logic en_ff;
	logic events_on;
	logic halt_en;
	logic mon_en;
	logic irq_ok;
	dme_state_e state_ff;
	dme_state_e nxt_state;
	logic mon_pulse_ff;
	logic wp_commit_ff;
	dme_match_if mif ();

	// Three-stage sync; a change counts when stages two and three agree.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			en_sync_ff <= 3'h0;
		end else begin
			en_sync_ff <= {en_sync_ff[1:0], invasive_debug_enable_i};
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			en_ff <= 1'b0;
		end else if (en_sync_ff[2] == en_sync_ff[1]) begin
			en_ff <= en_sync_ff[2];
		end
	end

	// The debug reset clears the register whatever the core is doing.
	always_ff @(posedge mclk_i or negedge debug_reset_n_i) begin
		if (!debug_reset_n_i) begin
			dscr_ff <= DSCR_RESET;
		end else if (dscr_wr_i) begin
			dscr_ff <= dscr_wdata_i;
		end
	end

	assign debug_status_control_reg_o = dscr_ff;
	assign halt_en = dscr_ff[HALT_BIT];
	assign mon_en = dscr_ff[MON_BIT];
	assign events_on = en_ff && (halt_en || mon_en);

	dme_matcher u_match (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.bp_addr_i(bp_addr_i),
		.bp_active_i(bp_active_i),
		.wp_addr_i(wp_addr_i),
		.wp_active_i(wp_active_i),
		.fetch_valid_i(fetch_valid_i),
		.fetch_addr_i(fetch_addr_i),
		.data_valid_i(data_valid_i),
		.data_addr_i(data_addr_i),
		.events_on_i(events_on),
		.m(mif.unit)
	);

	// A pending match is re-checked against the live enables every cycle,
	// so dropping them releases the stall instead of waiting forever.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			DME_IDLE: begin
				if (mif.bp_hit || mif.wp_hit) begin
					nxt_state = DME_PEND;
				end
			end
			DME_PEND: begin
				if (!events_on) begin
					nxt_state = DME_IDLE;
				end else if (instr_done_i) begin
					// Halt mode wins when both bits are set.
					nxt_state = halt_en ? DME_HALT : DME_MON;
				end
			end
			DME_HALT: begin
				if (restart_i || !events_on) begin
					nxt_state = DME_IDLE;
				end
			end
			DME_MON: begin
				nxt_state = DME_IDLE;
			end
			default: begin
				nxt_state = DME_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= DME_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mon_pulse_ff <= 1'b0;
		end else begin
			mon_pulse_ff <= (state_ff == DME_PEND) && instr_done_i &&
				events_on && !halt_en;
		end
	end

	// A watched access is committed whether or not debug stays on.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wp_commit_ff <= 1'b0;
		end else begin
			wp_commit_ff <= mif.wp_hit;
		end
	end

	assign irq_ok = irq_pending_i && !irq_masked_i;
	// Breakpoint and watchpoint matches both stall; interrupts still get through.
	assign core_stall_o = (state_ff == DME_PEND) && !irq_ok;
	assign irq_take_o = irq_ok && (state_ff != DME_HALT);
	// Halt is shown for the whole halted state, so the interrupt gate and
	// the halt output can never disagree after a late mode rewrite.
	assign halt_o = (state_ff == DME_HALT);
	assign monitor_exc_o = mon_pulse_ff;
	assign wp_data_commit_o = wp_commit_ff;
endmodule : dme_debug_ctrl

//--- tb/dme_debug_ctrl_checker.sv
`timescale 1ns/1ps
module dme_debug_ctrl_checker
	import dme_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic debug_reset_n_i,
	input wire logic invasive_debug_enable_i,
	input wire logic dscr_wr_i,
	input wire logic [31:0] dscr_wdata_i,
	input wire logic [31:0] debug_status_control_reg_o,
	input wire logic instr_done_i,
	input wire logic irq_pending_i,
	input wire logic irq_masked_i,
	input wire logic core_stall_o,
	input wire logic halt_o,
	input wire logic monitor_exc_o,
	input wire logic irq_take_o
);
	logic [1:0] md;
	assign md = debug_status_control_reg_o[MODE_MSB:MODE_LSB];
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	a_reg_write: assert property (dscr_wr_i |=>
		md == $past(dscr_wdata_i[15:14]) || !debug_reset_n_i) else $error("write");
	a_dbg_reset: assert property (!debug_reset_n_i |->
		debug_status_control_reg_o == DSCR_RESET) else $error("not cleared");
	a_quiet_pin: assert property ((!invasive_debug_enable_i)[*8] |->
		!core_stall_o && !halt_o && !monitor_exc_o) else $error("event off");
	a_quiet_mode: assert property ((md == 2'h0)[*8] |->
		!core_stall_o && !halt_o && !monitor_exc_o) else $error("event off");
	a_irq_unstall: assert property (irq_pending_i && !irq_masked_i |->
		!core_stall_o) else $error("irq stalled");
	a_irq_take: assert property (irq_take_o ==
		(irq_pending_i && !irq_masked_i && !halt_o)) else $error("irq take");
	// Seven enabled cycles outlast the pin synchroniser.
	a_halt_done: assert property (invasive_debug_enable_i[*7] ##0
		(core_stall_o && instr_done_i && md[1] && !dscr_wr_i) |=> halt_o)
		else $error("no halt");
	a_mon_done: assert property (invasive_debug_enable_i[*7] ##0
		(core_stall_o && instr_done_i && md == 2'h1 && !dscr_wr_i) |=>
		monitor_exc_o ##1 !monitor_exc_o) else $error("no monitor");
	c_halt: cover property (halt_o);
	c_mon: cover property (monitor_exc_o);
	c_irq: cover property (irq_take_o && irq_pending_i);
endmodule : dme_debug_ctrl_checker
bind dme_debug_ctrl dme_debug_ctrl_checker i_dme_debug_ctrl_checker (.*);

//--- tb/dme_dbg_model.sv
`timescale 1ns/1ps
module dme_dbg_model (
	input wire logic mclk_i,
	output logic en_o,
	output logic wr_o,
	output logic [31:0] wdata_o,
	output logic [3:0] bp_o,
	output logic [3:0] wp_o
);
	initial {en_o, wr_o, wdata_o, bp_o, wp_o} = '0;
	// Without tidy the units stay armed, which is the misuse to survive.
	task automatic set(input logic e, input logic [1:0] m, input bit tidy);
		@(negedge mclk_i);
		if (tidy) begin
			{bp_o, wp_o} = 8'h00;
			@(negedge mclk_i);
		end
		en_o = e;
		wr_o = 1'b1;
		wdata_o = {16'h0, m, 14'h0};
		@(negedge mclk_i);
		wr_o = 1'b0;
		if (tidy) begin
			repeat (6) @(negedge mclk_i);
			{bp_o, wp_o} = 8'hff;
		end
	endtask : set
endmodule : dme_dbg_model

//--- tb/debug_mode_enable_ctrl_tb_top.sv
`timescale 1ns/1ps
module debug_mode_enable_ctrl_tb_top;
	import dme_pkg::*;
	logic mclk_i = 0, reset_n_i = 0, debug_reset_n_i = 0, dscr_wr_i, hq = 0;
	logic invasive_debug_enable_i, fetch_valid_i = 0, data_valid_i = 0;
	logic instr_done_i = 0, irq_pending_i = 0, irq_masked_i = 0, restart_i = 0;
	logic core_stall_o, halt_o, monitor_exc_o, wp_data_commit_o, irq_take_o;
	logic [31:0] dscr_wdata_i, debug_status_control_reg_o, fetch_addr_i = 0;
	logic [31:0] data_addr_i = 0;
	logic [127:0] bp_addr_i = 0, wp_addr_i = 0;
	logic [3:0] bp_active_i, wp_active_i;
	logic [1:0] exp_q[$], seen;
	int failures = 0, n_compared = 0;
	always #12.5 mclk_i = ~mclk_i;
	dme_debug_ctrl i_dme_debug_ctrl (.*);
	dme_dbg_model i_dme_dbg_model (.mclk_i, .en_o(invasive_debug_enable_i),
		.wr_o(dscr_wr_i), .wdata_o(dscr_wdata_i), .bp_o(bp_active_i),
		.wp_o(wp_active_i));
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(negedge mclk_i);
	endtask : tick
	task automatic hit(bit w);
		int k;
		k = $urandom_range(3);
		fetch_addr_i = bp_addr_i[32*k +: 32];
		data_addr_i = wp_addr_i[32*k +: 32];
		{fetch_valid_i, data_valid_i} = {!w, w};
		tick(1);
		{fetch_valid_i, data_valid_i} = 2'h0;
	endtask : hit
	task automatic finish_hit(logic [1:0] ev);
		exp_q.push_back(ev);
		instr_done_i = 1;
		tick(1);
		{instr_done_i, restart_i} = 2'h1;
		tick(1);
		restart_i = 0;
		tick(1);
		chk("halt", 0, halt_o);
	endtask : finish_hit
	task automatic wrap_up;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	always @(negedge mclk_i) begin
		seen = halt_o && !hq ? 2'h1 : monitor_exc_o ? 2'h2 : {2{wp_data_commit_o}};
		hq = halt_o;
		if (reset_n_i && seen !== 2'h0)
			chk("event", exp_q.size() ? exp_q.pop_front() : 2'h0, seen);
	end
	initial begin
		logic [2:0] cfg [5] = '{3'h6, 3'h5, 3'h7, 3'h2, 3'h4};
		void'($urandom(90));
		bp_addr_i = {$urandom, $urandom, $urandom, $urandom};
		wp_addr_i = {$urandom, $urandom, $urandom, $urandom};
		tick(20);
		{reset_n_i, debug_reset_n_i} = 2'h3;
		foreach (cfg[i]) begin
			i_dme_dbg_model.set(cfg[i][2], cfg[i][1:0], 1);
			chk("mode", cfg[i][1:0], debug_status_control_reg_o[15:14]);
			hit(0);
			tick(2);
			chk("stall", cfg[i][2] && |cfg[i][1:0], core_stall_o);
			if (cfg[i][2] && |cfg[i][1:0]) finish_hit(cfg[i][1] ? 2'h1 : 2'h2);
		end
		i_dme_dbg_model.set(1, 2'h2, 1);
		hit(0);
		{irq_pending_i, irq_masked_i} = 2'h3;
		tick(3);
		chk("stall", 1, core_stall_o);
		irq_masked_i = 0;
		tick(1);
		chk("take", 1, irq_take_o);
		irq_pending_i = 0;
		tick(1);
		finish_hit(2'h1);
		for (int w = 1; w >= 0; w--) begin
			i_dme_dbg_model.set(1, 2'h2, 1);
			hit(w);
			if (w) exp_q.push_back(2'h3);
			// Pass one clears both mode bits, pass two drops the enable pin.
			i_dme_dbg_model.set(w, w ? 2'h0 : 2'h2, 0);
			for (int j = 0; j < 12 && core_stall_o !== 1'b0; j++) tick(1);
			chk("stall", 0, core_stall_o);
		end
		i_dme_dbg_model.set(1, 2'h3, 0);
		debug_reset_n_i = 0;
		tick(1);
		chk("dscr", DSCR_RESET, debug_status_control_reg_o);
		debug_reset_n_i = 1;
		chk("queue", 0, exp_q.size());
		wrap_up();
	end
endmodule : debug_mode_enable_ctrl_tb_top
